// ==== hdl/eeprom_slave.sv ====
/*
  Two-wire serial EEPROM slave: start/stop detection, address decode,
  byte write with page wrap, sequential read, write protect and busy lockout.
  Assumes a free-running link sampling clock; bus pins, straps and write
  protect are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

// Operation
// - All data is sampled and shifted on edges of the external serial clock.
// - Data line is only pulled low or released, open-drain style.
// - Data changes only while clock is low; high-clock changes mean start or stop.
// - Falling data with clock high is a start; nothing is answered before one.
// - Rising data with clock high is a stop, returning to standby.
// - Clock or data pulses shorter than 100 ns or 50 ns are ignored.
// - Transmitter releases after eight bits; receiver pulls low on the ninth clock.
// - Top four address bits must equal 1010 to select the device.
// - Active chip-select address bits must match the strapped pin levels.
// - Lowest zero to three chip-select bits pick the page block instead.
// - Each page block holds sixteen pages of sixteen bytes.
// - Device acknowledges a start followed by its own slave address.
// - Once selected for write, every further received byte is acknowledged, except data bytes under write protect.
// - In read, release after eight bits, sample acknowledge, then send next byte.
// - Without acknowledge after a read byte, stop sending and await the stop.
// - Write protect high blocks all programming; reads stay allowed.
// - Program cycle starts at the stop ending a write and lasts 10 or 15 ms.
// - During the program cycle the address is not acknowledged, line released.
// - Last slave address bit: one means read, zero means write.
// - A write carries an eight-bit word address within the page block.
// - Page write address wraps within the sixteen-byte page.
// - Under write protect the first data byte is not acknowledged, no program.
module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int PAGE_BLOCK_BITS = 0,
  parameter bit FAST_MODE       = 1'b0,
  parameter bit LOW_VOLTAGE     = 1'b0,
  parameter int PROG_CYCLES     = LOW_VOLTAGE ? PROG_LV_CYCLES : PROG_STD_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic link_clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output var  logic sda_o,
  output var  logic sda_oe_n_o,
  input  wire logic chip_select_pin_0_i,
  input  wire logic chip_select_pin_1_i,
  input  wire logic chip_select_pin_2_i,
  input  wire logic write_protect_i,
  output var  logic prog_busy_o
);

  localparam int ADDR_W    = BYTE_BITS + PAGE_BLOCK_BITS;
  localparam int MEM_DEPTH = BLOCK_BYTES << PAGE_BLOCK_BITS;
  localparam logic [2:0] BLK_MASK = 3'((1 << PAGE_BLOCK_BITS) - 1);
  localparam logic [FULL_ADDR_W-1:0] ADDR_MASK = FULL_ADDR_W'((1 << ADDR_W) - 1);
  localparam int FILT_CYCLES = FAST_MODE ? GLITCH_FAST_CYCLES : GLITCH_STD_CYCLES;

  initial begin
    if (PAGE_BLOCK_BITS < 0 || PAGE_BLOCK_BITS > MAX_PAGE_BLOCK_BITS) begin
      $error("eeprom_slave: PAGE_BLOCK_BITS must be 0 to 3");
    end
  end

  // Chip-select bits not used for the page block must equal the straps
  function automatic logic cs_match(input logic [2:0] sent, input logic [2:0] pins);
    return ((sent ^ pins) & ~BLK_MASK) == 3'h0;
  endfunction

  // Link-domain reset and pin synchronisers
  logic       link_rst_meta;
  logic       link_rst;
  logic       scl_meta;
  logic       scl_sync;
  logic       sda_meta;
  logic       sda_sync;
  logic [2:0] cs_meta;
  logic [2:0] cs_sync;
  logic       wp_meta;
  logic       wp_sync;
  logic       busy_meta;
  logic       busy_sync;

  always_ff @(posedge link_clk_i) begin
    link_rst_meta <= sys_rst_i;
    link_rst      <= link_rst_meta;
  end

  // The serial clock is only ever an input here
  always_ff @(posedge link_clk_i) begin
    scl_meta  <= scl_i;
    scl_sync  <= scl_meta;
    sda_meta  <= sda_i;
    sda_sync  <= sda_meta;
    cs_meta   <= {chip_select_pin_2_i, chip_select_pin_1_i, chip_select_pin_0_i};
    cs_sync   <= cs_meta;
    wp_meta   <= write_protect_i;
    wp_sync   <= wp_meta;
    busy_meta <= prog_busy_o;
    busy_sync <= busy_meta;
  end

  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;

  glitch_filter #(.STABLE_CYCLES(FILT_CYCLES)) u_scl_filt (
    .clk_i  (link_clk_i),
    .rst_i  (link_rst),
    .raw_i  (scl_sync),
    .filt_o (scl_f)
  );

  glitch_filter #(.STABLE_CYCLES(FILT_CYCLES)) u_sda_filt (
    .clk_i  (link_clk_i),
    .rst_i  (link_rst),
    .raw_i  (sda_sync),
    .filt_o (sda_f)
  );

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // Serial clock edges move data; data edges with clock high frame the transfer
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_f && !scl_q;
  assign scl_fall  = !scl_f && scl_q;
  assign start_det = scl_f && scl_q && sda_q && !sda_f;
  assign stop_det  = scl_f && scl_q && !sda_q && sda_f;

  // Transfer state
  bus_state_t             state;
  logic [3:0]             bit_cnt;
  logic [7:0]             shift;
  logic                   rd_mode;
  logic [FULL_ADDR_W-1:0] addr;
  logic [7:0]             rd_byte;
  logic                   wr_seen;
  logic                   prog_tgl;
  logic                   pending;
  logic                   busy_link;
  logic [7:0]             mem [0:MEM_DEPTH-1];

  assign busy_link = pending || busy_sync;

  // Event strobes shared by the state, address and memory processes
  logic dev_done;
  logic dev_hit;
  logic word_done;
  logic data_done;
  logic byte_load;

  assign dev_done  = state == ST_DEV_ADDR && scl_fall && bit_cnt == BITS_DONE;
  assign dev_hit   = shift[7:TYPE_FIELD_LSB] == DEVICE_TYPE_CODE
                     && cs_match(shift[TYPE_FIELD_LSB-1:CS_FIELD_LSB], cs_sync)
                     && !busy_link;
  assign word_done = state == ST_WORD_ADDR && scl_fall && bit_cnt == BITS_DONE;
  assign data_done = state == ST_WR_DATA && scl_fall && bit_cnt == BITS_DONE;
  assign byte_load = scl_fall && ((state == ST_DEV_ACK && rd_mode)
                     || (state == ST_RD_DATA && bit_cnt == 4'h0));

  // Open-drain data pin: the driven level is always low
  always_ff @(posedge link_clk_i) begin
    sda_o <= 1'b0;
  end

  // Bit-level protocol engine
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      rd_mode    <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end else if (start_det) begin
      state      <= ST_DEV_ADDR;
      bit_cnt    <= 4'h0;
      sda_oe_n_o <= 1'b1;
    end else if (stop_det) begin
      state      <= ST_IDLE;
      sda_oe_n_o <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          sda_oe_n_o <= 1'b1;
        end
        ST_DEV_ADDR, ST_WORD_ADDR, ST_WR_DATA: begin
          if (scl_rise && bit_cnt != BITS_DONE) begin
            shift   <= {shift[6:0], sda_f};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BITS_DONE) begin
            bit_cnt <= 4'h0;
            if (state == ST_DEV_ADDR) begin
              if (dev_hit) begin
                sda_oe_n_o <= 1'b0;
                rd_mode    <= shift[RW_BIT_POS];
                state      <= ST_DEV_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end else if (state == ST_WORD_ADDR) begin
              sda_oe_n_o <= 1'b0;
              state      <= ST_WORD_ACK;
            end else if (!wp_sync) begin
              sda_oe_n_o <= 1'b0;
              state      <= ST_WR_ACK;
            end else begin
              state <= ST_WAIT_STOP;
            end
          end
        end
        ST_DEV_ACK: begin
          if (scl_fall) begin
            if (rd_mode) begin
              sda_oe_n_o <= rd_byte[7];
              shift      <= {rd_byte[6:0], 1'b1};
              bit_cnt    <= 4'h1;
              state      <= ST_RD_DATA;
            end else begin
              sda_oe_n_o <= 1'b1;
              state      <= ST_WORD_ADDR;
            end
          end
        end
        ST_WORD_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_n_o <= 1'b1;
            state      <= ST_WR_DATA;
          end
        end
        ST_RD_DATA: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h0) begin
              sda_oe_n_o <= rd_byte[7];
              shift      <= {rd_byte[6:0], 1'b1};
              bit_cnt    <= 4'h1;
            end else if (bit_cnt == BITS_DONE) begin
              sda_oe_n_o <= 1'b1;
              state      <= ST_RD_ACK;
            end else begin
              sda_oe_n_o <= shift[7];
              shift      <= {shift[6:0], 1'b1};
              bit_cnt    <= bit_cnt + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            bit_cnt <= 4'h0;
            if (sda_f) begin
              state <= ST_WAIT_STOP;
            end else begin
              state <= ST_RD_DATA;
            end
          end
        end
        ST_WAIT_STOP: begin
          sda_oe_n_o <= 1'b1;
        end
        default: begin
          state      <= ST_IDLE;
          sda_oe_n_o <= 1'b1;
        end
      endcase
    end
  end

  // Address counter: block from slave address, byte from word address
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      addr <= ADDR_RESET;
    end else if (!start_det && !stop_det) begin
      if (dev_done && dev_hit) begin
        addr[FULL_ADDR_W-1:BYTE_BITS] <= shift[TYPE_FIELD_LSB-1:CS_FIELD_LSB] & BLK_MASK;
      end else if (word_done) begin
        addr[BYTE_BITS-1:0] <= shift;
      end else if (data_done && !wp_sync) begin
        addr[3:0] <= addr[3:0] + 4'h1;
      end else if (byte_load) begin
        addr <= (addr + 11'h001) & ADDR_MASK;
      end
    end
  end

  // Array write and read-ahead of the byte at the counter
  always_ff @(posedge link_clk_i) begin
    if (data_done && !wp_sync && !start_det && !stop_det) begin
      mem[addr[ADDR_W-1:0]] <= shift;
    end
  end

  always_ff @(posedge link_clk_i) begin
    rd_byte <= mem[addr[ADDR_W-1:0]];
  end

  // Program request at the stop that ends an accepted write
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      wr_seen  <= 1'b0;
      prog_tgl <= 1'b0;
    end else if (stop_det && wr_seen) begin
      wr_seen  <= 1'b0;
      prog_tgl <= !prog_tgl;
    end else if (start_det) begin
      wr_seen <= 1'b0;
    end else if (data_done && !wp_sync) begin
      wr_seen <= 1'b1;
    end
  end

  // Covers the gap until the system domain's busy returns; set wins
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      pending <= 1'b0;
    end else if (stop_det && wr_seen) begin
      pending <= 1'b1;
    end else if (busy_sync) begin
      pending <= 1'b0;
    end
  end

  // System domain: toggle crossing into the self-timed program counter
  logic prog_meta;
  logic prog_s1;
  logic prog_s2;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prog_meta <= 1'b0;
      prog_s1   <= 1'b0;
      prog_s2   <= 1'b0;
    end else begin
      prog_meta <= prog_tgl;
      prog_s1   <= prog_meta;
      prog_s2   <= prog_s1;
    end
  end

  program_timer #(.PROG_CYCLES(PROG_CYCLES)) u_timer (
    .clk_i   (clk_i),
    .rst_i   (sys_rst_i),
    .start_i (prog_s1 ^ prog_s2),
    .busy_o  (prog_busy_o)
  );

  start_decode_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    start_det |=> state == ST_DEV_ADDR && bit_cnt == 4'h0 && sda_oe_n_o)
    else $error("start did not open address reception");

  stop_standby_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    stop_det && !start_det |=> state == ST_IDLE && sda_oe_n_o)
    else $error("stop did not return to standby");

  addr_ack_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    state == ST_DEV_ACK |-> !sda_oe_n_o && shift[7:4] == DEVICE_TYPE_CODE
      && cs_match(shift[3:1], cs_sync))
    else $error("address acknowledge without a matching address");

  word_ack_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    state == ST_WORD_ACK || state == ST_WR_ACK |-> !sda_oe_n_o)
    else $error("received write byte not acknowledged");

  busy_silent_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    dev_done && busy_link && !start_det && !stop_det |=> state == ST_IDLE ##1 sda_oe_n_o)
    else $error("device answered while programming");

  wp_withhold_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    data_done && wp_sync && !start_det && !stop_det |=> state == ST_WAIT_STOP && sda_oe_n_o)
    else $error("protected data byte was acknowledged");

  rd_release_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    state == ST_RD_ACK |-> sda_oe_n_o)
    else $error("data line held during read acknowledge");

  rd_nack_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    state == ST_RD_ACK && scl_rise && sda_f && !start_det && !stop_det
      |=> state == ST_WAIT_STOP [*2])
    else $error("read continued without acknowledge");

  page_wrap_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    data_done && !wp_sync && !start_det && !stop_det
      |=> addr[3:0] == $past(addr[3:0]) + 4'h1 && addr[10:4] == $past(addr[10:4]))
    else $error("page write address left its page");

  prog_req_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    $changed(prog_tgl) |-> $past(stop_det) && $past(wr_seen))
    else $error("program requested without a finished write");

endmodule

`default_nettype wire

// ==== hdl/glitch_filter.sv ====
/*
  Digital noise suppressor for one already-synchronised line.
  Assumes the input has passed a two-flop synchroniser on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module glitch_filter #(
  parameter int STABLE_CYCLES = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic raw_i,
  output var  logic filt_o
);

  localparam int CNT_W = $clog2(STABLE_CYCLES + 1);

  logic [CNT_W-1:0] cnt;

  initial begin
    if (STABLE_CYCLES < 1) begin
      $error("glitch_filter: STABLE_CYCLES must be at least 1");
    end
  end

  // Output follows the input only after it has differed for STABLE_CYCLES samples
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_o <= 1'b1;
      cnt    <= '0;
    end else if (raw_i != filt_o) begin
      if (cnt == CNT_W'(STABLE_CYCLES - 1)) begin
        filt_o <= raw_i;
        cnt    <= '0;
      end else begin
        cnt <= cnt + CNT_W'(1);
      end
    end else begin
      cnt <= '0;
    end
  end

  filter_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(filt_o) |-> $past(cnt) == CNT_W'(STABLE_CYCLES - 1) && $past(raw_i) == filt_o)
    else $error("filtered line changed before the input was stable long enough");

endmodule

`default_nettype wire

// ==== hdl/program_timer.sv ====
/*
  Self-timed program cycle timer on the system clock.
  Assumes start_i is a single-cycle pulse already in the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module program_timer #(
  parameter int PROG_CYCLES = 2000000
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output var  logic busy_o
);

  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  logic [CNT_W-1:0] cnt;

  initial begin
    if (PROG_CYCLES < 32) begin
      $error("program_timer: PROG_CYCLES too short for the link to see busy");
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      cnt    <= '0;
    end else if (start_i && !busy_o) begin
      busy_o <= 1'b1;
      cnt    <= '0;
    end else if (busy_o) begin
      if (cnt == CNT_W'(PROG_CYCLES - 1)) begin
        busy_o <= 1'b0;
      end else begin
        cnt <= cnt + CNT_W'(1);
      end
    end
  end

  timer_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && !busy_o |=> busy_o && cnt == '0)
    else $error("program cycle did not start on request");

  timer_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(busy_o) |-> $past(cnt) == CNT_W'(PROG_CYCLES - 1))
    else $error("program cycle ended at the wrong count");

endmodule

`default_nettype wire

// ==== shared/eeprom_pkg.sv ====
/*
  Shared constants and types for the two-wire serial EEPROM slave.
  Assumes a 200 MHz system clock and a free-running 48 ns link sampling clock.
*/
package eeprom_pkg;

  // Clock rates
  localparam int SYS_CLK_KHZ        = 200000;
  localparam int LINK_CLK_PERIOD_NS = 48;

  // Noise suppression limits and their link-clock counts (least time, rounded up)
  localparam int GLITCH_FILTER_TIME_STD_NS  = 100;
  localparam int GLITCH_FILTER_TIME_FAST_NS = 50;
  localparam int GLITCH_STD_CYCLES  =
    (GLITCH_FILTER_TIME_STD_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;
  localparam int GLITCH_FAST_CYCLES =
    (GLITCH_FILTER_TIME_FAST_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;

  // Internal program time and its system-clock counts (longest time, rounded down)
  localparam int INTERNAL_PROGRAM_TIME_STD_MS = 10;
  localparam int INTERNAL_PROGRAM_TIME_LV_MS  = 15;
  localparam int PROG_STD_CYCLES = INTERNAL_PROGRAM_TIME_STD_MS * SYS_CLK_KHZ;
  localparam int PROG_LV_CYCLES  = INTERNAL_PROGRAM_TIME_LV_MS * SYS_CLK_KHZ;

  // Slave address layout
  localparam logic [3:0] DEVICE_TYPE_CODE = 4'hA;
  localparam int         RW_BIT_POS       = 0;
  localparam int         CS_FIELD_LSB     = 1;
  localparam int         TYPE_FIELD_LSB   = 4;

  // Array organisation
  localparam int BYTE_BITS            = 8;
  localparam int PAGE_BYTES           = 16;
  localparam int BLOCK_BYTES          = 256;
  localparam int MAX_PAGE_BLOCK_BITS  = 3;
  localparam int FULL_ADDR_W          = 11;

  // Address value after reset and bit count of a full byte
  localparam logic [FULL_ADDR_W-1:0] ADDR_RESET = 11'h000;
  localparam logic [3:0]             BITS_DONE  = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEV_ADDR,
    ST_DEV_ACK,
    ST_WORD_ADDR,
    ST_WORD_ACK,
    ST_WR_DATA,
    ST_WR_ACK,
    ST_RD_DATA,
    ST_RD_ACK,
    ST_WAIT_STOP
  } bus_state_t;

endpackage

// ==== tb/bus_master_model.sv ====
/*
  Two-wire bus master model: drives the serial clock and the data line.
  Assumes the bench ANDs all data drivers with a pull-up to form the wire.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Start, bit and glitch steps end 60 cycles after the clock fell, so data never moves near an edge
  task automatic start_cond();
    sda_o = 1'b1;
    wait_clk(140);
    scl_o = 1'b1;
    wait_clk(140);
    sda_o = 1'b0;
    wait_clk(140);
    scl_o = 1'b0;
    wait_clk(60);
  endtask

  task automatic stop_cond();
    sda_o = 1'b0;
    wait_clk(140);
    scl_o = 1'b1;
    wait_clk(140);
    sda_o = 1'b1;
    wait_clk(140);
  endtask

  task automatic bit_xfer(input logic b, output logic r);
    sda_o = b;
    wait_clk(140);
    scl_o = 1'b1;
    wait_clk(60);
    r = sda_i;
    wait_clk(60);
    scl_o = 1'b0;
    wait_clk(60);
  endtask

  // Ninth bit: released when receiving the answer, driven when answering
  task automatic byte_xfer(input logic [7:0] d, input logic last,
                           output logic [7:0] q, output logic nine);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], q[i]);
    end
    bit_xfer(last, nine);
  endtask

  // Clock pulse of 40 ns, below the noise limit
  task automatic glitch();
    scl_o = 1'b1;
    wait_clk(8);
    scl_o = 1'b0;
    wait_clk(60);
  endtask
endmodule

`default_nettype wire

// ==== tb/serial_eeprom_two_wire_slave_test.sv ====
/*
  Self-checking bench for the two-wire EEPROM slave with one page-block bit.
  Assumes straps start with chip_select_pin_1 high, the other two low.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_two_wire_slave_test;
  import eeprom_pkg::*;
  localparam int PROG = 4000;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic wp = 1'b0;
  logic cs0 = 1'b0;
  logic cs1 = 1'b1;
  logic cs2 = 1'b0;
  logic scl;
  logic m_sda;
  logic sda_o;
  logic sda_oe_n;
  logic busy;
  wire logic sda = m_sda & (sda_oe_n | sda_o);
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int busy_run = 0;
  int busy_len = 0;

  always #2.5 clk = ~clk;
  always #24 link_clk = ~link_clk;

  eeprom_slave #(.PAGE_BLOCK_BITS(1), .PROG_CYCLES(PROG)) DUT (
    .clk_i(clk), .sys_rst_i(rst), .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .chip_select_pin_0_i(cs0),
    .chip_select_pin_1_i(cs1), .chip_select_pin_2_i(cs2),
    .write_protect_i(wp), .prog_busy_o(busy)
  );

  bus_master_model master (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (busy === 1'b1) busy_run <= busy_run + 1;
    else if (busy_run != 0) begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
    if (sda_oe_n === 1'b0) check(sda_o, 1'b0, "drive level");
    if (cyc == 90000) begin
      fail_count++;
      $display("BAD %0t run too long", $time);
      give_verdict();
    end
  end

  // Sends a byte and compares the answer bit: acked means the wire was low
  task automatic wr(input logic [7:0] b, input logic acked);
    logic [7:0] q;
    logic nine;
    master.byte_xfer(b, 1'b1, q, nine);
    check(nine, !acked, "answer bit");
  endtask

  task automatic rd(input logic [7:0] exp, input logic last);
    logic [7:0] q;
    logic nine;
    master.byte_xfer(8'hFF, last, q, nine);
    check(q, exp, "read byte");
  endtask

  task automatic t_reset();
    check(sda_oe_n, 1'b1, "idle release");
    check(busy, 1'b0, "idle busy");
    $display("reset test done");
  endtask

  task automatic t_write();
    master.start_cond();
    wr(8'hA6, 1'b1);
    wr(8'h0E, 1'b1);
    wr(8'h11, 1'b1);
    master.glitch();
    wr(8'h22, 1'b1);
    wr(8'h33, 1'b1);
    master.stop_cond();
    master.wait_clk(40);
    check(busy, 1'b1, "program started");
    master.start_cond();
    wr(8'hA6, 1'b0);
    master.stop_cond();
    for (int i = 0; i < 6000 && busy !== 1'b0; i++) master.wait_clk(1);
    master.wait_clk(4);
    check(busy_len, PROG, "program length");
    $display("write test done");
  endtask

  task automatic t_refuse();
    master.start_cond();
    wr(8'hB6, 1'b0);
    master.start_cond();
    wr(8'hA2, 1'b0);
    master.stop_cond();
    $display("refuse test done");
  endtask

  // Moves one strap: the old address is refused, the address matching the new straps is acknowledged
  task automatic t_strap();
    cs2 = 1'b1;
    master.start_cond();
    wr(8'hA6, 1'b0);
    master.start_cond();
    wr(8'hAC, 1'b1);
    master.stop_cond();
    cs2 = 1'b0;
    $display("strap test done");
  endtask

  task automatic t_protect();
    wp = 1'b1;
    master.start_cond();
    wr(8'hA6, 1'b1);
    wr(8'h0E, 1'b1);
    wr(8'h77, 1'b0);
    master.stop_cond();
    master.wait_clk(40);
    check(busy, 1'b0, "no program");
    wp = 1'b0;
    $display("protect test done");
  endtask

  task automatic t_read();
    master.start_cond();
    wr(8'hA6, 1'b1);
    wr(8'h0E, 1'b1);
    master.start_cond();
    wr(8'hA7, 1'b1);
    rd(8'h11, 1'b0);
    rd(8'h22, 1'b1);
    rd(8'hFF, 1'b1);
    master.stop_cond();
    master.start_cond();
    wr(8'hA6, 1'b1);
    wr(8'h00, 1'b1);
    master.start_cond();
    wr(8'hA7, 1'b1);
    rd(8'h33, 1'b1);
    master.stop_cond();
    $display("read test done");
  endtask

  initial begin
    repeat (40) @(negedge clk);
    rst = 1'b0;
    repeat (100) @(negedge clk);
    t_reset();
    t_write();
    t_refuse();
    t_strap();
    t_protect();
    t_read();
    give_verdict();
  end
endmodule

`default_nettype wire
